/* verilog/accel_spi_defines.svh */
`ifndef ACCEL_SPI_DEFINES_SVH
`define ACCEL_SPI_DEFINES_SVH

// Command word fields
`define CMD_SEL_BIT 15
`define CMD_AXIS_BIT 14
`define CMD_ACC_BIT 13
`define ADDR_MSB 12
`define ADDR_LSB 8
`define FRAME_BITS 5'h10

// Response word fields
`define RSP_AXIS_BIT 13
`define RSP_PAR_BIT 12
`define RSP_STAT_MSB 11
`define RSP_STAT_LSB 10

// Status codes in bits 11:10
`define STAT_ACCEL 2'h1
`define STAT_SELFTEST 2'h2
`define STAT_ERROR 2'h3

// Error flag positions in bits 9:0
`define FLG_ND_BIT 4
`define FLG_HE_BIT 3
`define FLG_CNC_BIT 2
`define FLG_REQ_BIT 1
`define FLG_SPI_BIT 0

// Register addresses
`define ADDR_DEVICE_CONTROL_REGISTER 5'h00
`define ADDR_TEMP 5'h0F
`define ADDR_DEVSTAT 5'h10
`define ADDR_COUNT 5'h11

// Control register layout
`define CTL_ST0 0
`define CTL_ST1 1
`define CTL_FILTER_BYPASS_BIT 3
`define CTL_CE 4
`define CTL_READ_MASK 8'h0B
`define CTL_RESET 8'h00

// Status register layout
`define STAT_IDE 7
`define STAT_OSCF 6
`define STAT_DEVINIT 5
`define STAT_TF 4
`define STAT_HPF 3
`define STAT_OFF_Y 2
`define STAT_OFF_X 1
`define STAT_DEVRES 0

// Request error frame without parity; also the value after reset
`define REQ_ERR_FRAME 16'h0C02

// Command queue depth
`define CMD_FIFO_DEPTH 8

`endif

/* verilog/accel_spi_pkg.sv */
package accel_spi_pkg;

  typedef struct packed {
    logic spi_err;
    logic [15:0] word;
  } cmd_frame_t;

  typedef enum logic [1:0] {
    OP_UNUSED,
    OP_WRITE,
    OP_READ,
    OP_TEST
  } op_t;

  typedef enum logic {
    LINK_IDLE,
    LINK_ACTIVE
  } link_state_t;

  typedef struct packed {
    logic osc_running;
    logic osc_freq_fail;
    logic over_temp;
    logic offset_x;
    logic offset_y;
    logic parity_err;
    logic init_busy;
  } fault_in_t;

  typedef struct packed {
    logic filter_bypass_bit;
    logic selftest_direction_bit;
    logic selftest_enable_bit;
  } ctrl_out_t;

  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] mosi_sync;
    logic sclk_prev;
    logic cs_prev;
    link_state_t link;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [4:0] rises;
    logic edge_err;
    logic [15:0] resp;
    logic resp_par;
    logic [7:0] ctrl;
    logic tf;
    logic off_x;
    logic off_y;
    logic ide;
    logic devres;
    logic nd_pending;
    logic clear_error;
    logic overrun;
    logic miso;
    logic miso_oe;
  } core_state_t;

endpackage : accel_spi_pkg

/* verilog/cmd_fifo.sv */
`timescale 1ns/1ps
module cmd_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t s_ff;
  fifo_state_t nxt_s;
  logic push;
  logic pop;

  assign in_ready = s_ff.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_ff.cnt != '0;
  assign out_data = s_ff.mem[s_ff.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wr] = in_data;
      nxt_s.wr = (s_ff.wr == AW'(DEPTH - 1)) ? '0 : s_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_s.rd = (s_ff.rd == AW'(DEPTH - 1)) ? '0 : s_ff.rd + 1'b1;
    end
    if (push && !pop) begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_s.cnt = s_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule : cmd_fifo

/* verilog/accel_spi_frame.sv */
// How it works
// (RL1) Slave mode 0: idle-low clock, sample on rise, MSB first both ways.
// (RL2) Each frame answers the command of the previous frame.
// (RL3) With chip select high, clock and data input are ignored.
// (RL4) First frame after reset carries the request-error answer.
// (RL5) Bit 15 low, bit 13 high asks for acceleration; bit 14 picks Y.
// (RL6) Acceleration answer: value 9:0, axis bit 13, status bits 11:10.
// (RL7) Status 01 normal, 10 self-test, 11 error; never 00.
// (RL8) On error status, bits 9:0 carry error-type flags.
// (RL9) No-data flag during init and on first request after init.
// (RL10) Hardware error for over-temperature, offset or parity faults.
// (RL11) Oscillator counts as hardware error only while it still runs.
// (RL12) Bit 15 high on acceleration request gives CONDITIONS_NOT_CORRECT_FLAG, plus ND/HE.
// (RL13) Bit 13 low: bits 15:14 pick unused, write, read or test.
// (RL14) Register commands report only oscillator, framing or request errors.
// (RL15) Write carries address 12:8, data 7:0; only control writable.
// (RL16) Write answer shows bypass, self-test direction and enable bits.
// (RL17) Read: bit 15 high, 14:13 low, address 12:8, low byte ignored.
// (RL18) Read answer holds the register byte in bits 7:0.
// (RL19) Test command returns the status register in bits 7:0.
// (RL20) Status bit 0 set by reset until clear-error is written; the code keeps it set if that write comes during init.
// (RL21) Framing error: clock high at select edges or not 16 rises.
// (RL22) Register command with bits 15:14 zero is a request error.
// (RL23) With oscillator stopped, output stays high while selected.
// (RL24) Bit 12 of status frames is parity over the other bits.
`timescale 1ns/1ps
`include "accel_spi_defines.svh"
module accel_spi_frame #(
  parameter bit ODD_PARITY = 1'b1,
  parameter int FIFO_DEPTH = `CMD_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire accel_spi_pkg::fault_in_t faults,
  input wire logic [9:0] accel_x,
  input wire logic [9:0] accel_y,
  input wire logic [7:0] temp_value,
  input wire logic [7:0] count_value,
  output accel_spi_pkg::ctrl_out_t ctrl,
  output logic clear_error,
  output logic cmd_overrun
);

  accel_spi_pkg::core_state_t s_ff;
  accel_spi_pkg::core_state_t nxt_s;

  accel_spi_pkg::cmd_frame_t push_frame;
  accel_spi_pkg::cmd_frame_t pop_frame;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;

  // Insert bit 12 parity over the other fifteen bits
  function automatic logic [15:0] with_parity(input logic [15:0] w);
    logic [15:0] r;
    r = w;
    r[`RSP_PAR_BIT] = ODD_PARITY ^
      (^{w[15:`RSP_PAR_BIT+1], w[`RSP_PAR_BIT-1:0]}); // RL24
    return r;
  endfunction : with_parity

  // Error frame with flags in the low bits
  function automatic logic [15:0] err_frame(input logic [9:0] flags);
    logic [15:0] r;
    r = 16'h0000;
    r[`RSP_STAT_MSB:`RSP_STAT_LSB] = `STAT_ERROR; // RL8
    r[9:0] = flags; // RL8
    return r;
  endfunction : err_frame

  // Register answers echo the command head, no parity
  function automatic logic [15:0] reg_answer(
    input logic [15:0] cmd,
    input logic [4:0] addr,
    input logic [7:0] data
  );
    logic [15:0] r;
    r = {cmd[15:13], addr, data};
    return r;
  endfunction : reg_answer

  // Normal answer: axis, status and the selected sample
  function automatic logic [15:0] accel_answer(
    input logic axis,
    input logic selftest
  );
    logic [15:0] r;
    r = 16'h0000;
    r[`RSP_AXIS_BIT] = axis; // RL6
    r[`RSP_STAT_MSB:`RSP_STAT_LSB] = selftest ? `STAT_SELFTEST :
      `STAT_ACCEL; // RL7
    r[9:0] = axis ? accel_y : accel_x; // RL5
    return r;
  endfunction : accel_answer

  // Reset image: syncs at idle levels, request-error answer queued
  function automatic accel_spi_pkg::core_state_t reset_state();
    accel_spi_pkg::core_state_t r;
    r = '0;
    r.cs_sync = 2'h3;
    r.cs_prev = 1'b1;
    r.link = accel_spi_pkg::LINK_IDLE;
    r.resp = `REQ_ERR_FRAME; // RL4
    r.resp_par = 1'b1;
    r.ctrl = `CTL_RESET;
    r.devres = 1'b1; // RL20
    r.nd_pending = 1'b1; // RL9
    return r;
  endfunction : reset_state

  // Readable register byte by address
  function automatic logic [7:0] read_reg(
    input logic [4:0] addr,
    input logic [7:0] ctl,
    input logic [7:0] stat
  );
    logic [7:0] r;
    r = 8'h00;
    case (addr)
      `ADDR_DEVICE_CONTROL_REGISTER: r = ctl & `CTL_READ_MASK;
      `ADDR_TEMP: r = temp_value;
      `ADDR_DEVSTAT: r = stat;
      `ADDR_COUNT: r = count_value;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : read_reg

  cmd_fifo #(
    .WIDTH($bits(accel_spi_pkg::cmd_frame_t)),
    .DEPTH(FIFO_DEPTH)
  ) i_cmd_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_frame),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_frame)
  );

  assign miso = s_ff.miso;
  assign miso_oe = s_ff.miso_oe;
  assign clear_error = s_ff.clear_error;
  assign cmd_overrun = s_ff.overrun;
  assign ctrl.filter_bypass_bit = s_ff.ctrl[`CTL_FILTER_BYPASS_BIT];
  assign ctrl.selftest_direction_bit = s_ff.ctrl[`CTL_ST1];
  assign ctrl.selftest_enable_bit = s_ff.ctrl[`CTL_ST0];

  // Answers are only prepared between frames, never under the shifter
  assign pop_ready = (s_ff.link == accel_spi_pkg::LINK_IDLE) &&
    s_ff.cs_sync[1];

  always_comb begin
    logic sclk_rise;
    logic sclk_fall;
    logic cs_start;
    logic cs_end;
    logic ce;
    logic he;
    logic nd;
    logic acc_req;
    logic [4:0] addr;
    logic [7:0] stat;
    logic [9:0] flags;
    logic [15:0] cmd;
    accel_spi_pkg::op_t op;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    cs_start = 1'b0;
    cs_end = 1'b0;
    ce = 1'b0;
    he = 1'b0;
    nd = 1'b0;
    acc_req = 1'b0;
    addr = 5'h00;
    stat = 8'h00;
    flags = 10'h000;
    cmd = 16'h0000;
    op = accel_spi_pkg::OP_UNUSED;
    push_valid = 1'b0;
    push_frame = '0;

    nxt_s = s_ff;
    nxt_s.clear_error = 1'b0;
    nxt_s.overrun = 1'b0;
    nxt_s.sclk_sync = {s_ff.sclk_sync[0], sclk};
    nxt_s.cs_sync = {s_ff.cs_sync[0], cs_n};
    nxt_s.mosi_sync = {s_ff.mosi_sync[0], mosi};
    nxt_s.sclk_prev = s_ff.sclk_sync[1];
    nxt_s.cs_prev = s_ff.cs_sync[1];

    sclk_rise = s_ff.sclk_sync[1] && !s_ff.sclk_prev;
    sclk_fall = !s_ff.sclk_sync[1] && s_ff.sclk_prev;
    cs_start = s_ff.cs_prev && !s_ff.cs_sync[1];
    cs_end = !s_ff.cs_prev && s_ff.cs_sync[1];

    // Hardware error sources; a stopped oscillator is not one of them
    he = s_ff.tf | s_ff.off_x | s_ff.off_y | s_ff.ide | // RL10
      (faults.osc_freq_fail & faults.osc_running); // RL11
    nd = faults.init_busy | s_ff.nd_pending; // RL9

    stat[`STAT_IDE] = s_ff.ide;
    stat[`STAT_OSCF] = faults.osc_freq_fail & faults.osc_running;
    stat[`STAT_DEVINIT] = faults.init_busy;
    stat[`STAT_TF] = s_ff.tf;
    stat[`STAT_HPF] = !s_ff.ctrl[`CTL_FILTER_BYPASS_BIT] && !s_ff.ctrl[`CTL_ST0];
    stat[`STAT_OFF_Y] = s_ff.off_y;
    stat[`STAT_OFF_X] = s_ff.off_x;
    stat[`STAT_DEVRES] = s_ff.devres; // RL20

    case (s_ff.link)
      accel_spi_pkg::LINK_IDLE: begin
        // Nothing on the clock or data pins matters while deselected
        if (cs_start) begin // RL3
          nxt_s.link = accel_spi_pkg::LINK_ACTIVE;
          nxt_s.rises = 5'h00;
          nxt_s.edge_err = s_ff.sclk_sync[1]; // RL21
          // Queued answer of the previous command goes out now
          nxt_s.tx = s_ff.resp_par ? with_parity(s_ff.resp) :
            s_ff.resp; // RL2
        end
      end
      accel_spi_pkg::LINK_ACTIVE: begin
        if (sclk_rise) begin
          nxt_s.rx = {s_ff.rx[14:0], s_ff.mosi_sync[1]}; // RL1
          if (s_ff.rises != 5'h1F) begin
            nxt_s.rises = s_ff.rises + 5'h01;
          end
        end
        if (sclk_fall) begin
          nxt_s.tx = {s_ff.tx[14:0], 1'b0}; // RL1
        end
        if (cs_end) begin
          nxt_s.link = accel_spi_pkg::LINK_IDLE;
          push_valid = 1'b1;
          push_frame.word = s_ff.rx;
          push_frame.spi_err = s_ff.edge_err | s_ff.sclk_sync[1] |
            (s_ff.rises != `FRAME_BITS); // RL21
          // Queue full: the command is lost and flagged
          nxt_s.overrun = !push_ready;
        end
      end
      default: begin
        nxt_s.link = accel_spi_pkg::LINK_IDLE;
      end
    endcase

    if (pop_valid && pop_ready) begin
      cmd = pop_frame.word;
      addr = cmd[`ADDR_MSB:`ADDR_LSB];
      op = accel_spi_pkg::op_t'(cmd[`CMD_SEL_BIT:`CMD_AXIS_BIT]); // RL13
      acc_req = cmd[`CMD_ACC_BIT];
      nxt_s.resp_par = 1'b1;
      if (pop_frame.spi_err) begin
        flags[`FLG_SPI_BIT] = 1'b1;
        nxt_s.resp = err_frame(flags); // RL21
      end else if (acc_req) begin
        // Hardware error flag shows only in acceleration answers
        flags[`FLG_ND_BIT] = nd; // RL9
        flags[`FLG_HE_BIT] = he; // RL14
        if (cmd[`CMD_SEL_BIT]) begin
          flags[`FLG_CNC_BIT] = 1'b1;
          nxt_s.resp = err_frame(flags); // RL12
        end else if (nd || he) begin
          nxt_s.resp = err_frame(flags); // RL7
        end else begin
          nxt_s.resp = accel_answer(cmd[`CMD_AXIS_BIT],
            s_ff.ctrl[`CTL_ST0]); // RL6
        end
        // Once init is over, one no-data answer is still owed
        if (!faults.init_busy) begin
          nxt_s.nd_pending = 1'b0; // RL9
        end
      end else begin
        case (op)
          accel_spi_pkg::OP_WRITE: begin
            if (addr == `ADDR_DEVICE_CONTROL_REGISTER) begin
              nxt_s.ctrl = cmd[7:0] & `CTL_READ_MASK; // RL15
              ce = cmd[`CTL_CE];
              nxt_s.resp_par = 1'b0;
              nxt_s.resp = reg_answer(cmd, addr,
                cmd[7:0] & `CTL_READ_MASK); // RL16
            end else begin
              flags[`FLG_REQ_BIT] = 1'b1;
              nxt_s.resp = err_frame(flags); // RL15
            end
          end
          accel_spi_pkg::OP_READ: begin
            nxt_s.resp_par = 1'b0;
            nxt_s.resp = reg_answer(cmd, addr,
              read_reg(addr, s_ff.ctrl, stat)); // RL17 RL18
          end
          accel_spi_pkg::OP_TEST: begin
            nxt_s.resp_par = 1'b0;
            nxt_s.resp = reg_answer(cmd, `ADDR_DEVSTAT,
              read_reg(`ADDR_DEVSTAT, s_ff.ctrl, stat)); // RL19
          end
          default: begin
            flags[`FLG_REQ_BIT] = 1'b1;
            nxt_s.resp = err_frame(flags); // RL22
          end
        endcase
      end
    end

    // Sticky faults: a new event in the clearing cycle survives
    nxt_s.clear_error = ce;
    nxt_s.tf = (s_ff.tf & !ce) | faults.over_temp;
    nxt_s.off_x = (s_ff.off_x & !ce) | faults.offset_x;
    nxt_s.off_y = (s_ff.off_y & !ce) | faults.offset_y;
    nxt_s.ide = s_ff.ide | faults.parity_err;
    // Reset flag may only be dropped after initialization
    if (ce && !faults.init_busy) begin
      nxt_s.devres = 1'b0; // RL20
    end

    // Output stays high throughout a frame with a dead oscillator
    nxt_s.miso_oe = nxt_s.link == accel_spi_pkg::LINK_ACTIVE;
    if (!faults.osc_running) begin
      nxt_s.miso = nxt_s.miso_oe; // RL23
    end else begin
      nxt_s.miso = nxt_s.miso_oe & nxt_s.tx[15]; // RL1
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_ff <= reset_state();
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule : accel_spi_frame

/* dv/spi_master_model.sv */
`timescale 1ns/1ps
module spi_master_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Mode 0 master, 80 ns clock; miso read late in the high phase
  task automatic xfer(input logic [15:0] tx, input int rises,
                      output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    // Clock and data noise while deselected must not count
    repeat (2) begin
      #40 sclk = 1'b1;
      mosi = ~mosi;
      #40 sclk = 1'b0;
    end
    #80 cs_n = 1'b0;
    #80;
    for (i = 0; i < rises; i++) begin
      mosi = (i < 16) ? tx[15 - i] : 1'b0;
      #40 sclk = 1'b1;
      #38 rx = {rx[14:0], miso};
      #2 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    // Released line shows the inverse, never the last bit
    mosi = ~mosi;
    // Gap lets the answer for the next frame be built
    #400;
  endtask : xfer
endmodule : spi_master_model

/* dv/accel_spi_frame_chk.sv */
`timescale 1ns/1ps
module accel_spi_frame_chk #(
  parameter bit ODD_PARITY = 1'b1,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire accel_spi_pkg::fault_in_t faults,
  input wire logic [9:0] accel_x,
  input wire logic [9:0] accel_y,
  input wire logic [7:0] temp_value,
  input wire logic [7:0] count_value,
  input wire accel_spi_pkg::ctrl_out_t ctrl,
  input wire logic clear_error,
  input wire logic cmd_overrun
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  rst_quiet_a: assert property ($fell(reset) |-> !miso_oe && !miso
    && ctrl == '0 && !clear_error && !cmd_overrun)
    else $error("outputs not quiet after reset");
  idle_low_a: assert property (!miso_oe |-> !miso)
    else $error("miso high while not driven");
  deselect_a: assert property (cs_n [*5] |-> !miso_oe)
    else $error("miso driven while deselected");
  start_a: assert property ($rose(miso_oe) |-> !cs_n &&
    !$past(cs_n, 2)) else $error("frame started without select");
  start_bound_a: assert property ($fell(cs_n) ##1 (!cs_n) [*5]
    |-> miso_oe) else $error("frame not started in time");
  oe_hold_a: assert property (miso_oe && !cs_n |=> miso_oe)
    else $error("miso released inside frame");
  osc_high_a: assert property ((miso_oe && !faults.osc_running) [*3]
    |-> miso) else $error("miso low with oscillator stopped");
  ce_pulse_a: assert property (clear_error |=> !clear_error)
    else $error("clear pulse too long");
  ovr_pulse_a: assert property (cmd_overrun |=> !cmd_overrun)
    else $error("overrun pulse too long");
  ctrl_hold_a: assert property ((!cs_n) [*4] |-> $stable(ctrl))
    else $error("control bits changed inside frame");
endmodule : accel_spi_frame_chk

bind accel_spi_frame accel_spi_frame_chk #(
  .ODD_PARITY(ODD_PARITY),
  .FIFO_DEPTH(FIFO_DEPTH)
) i_accel_spi_frame_chk (.clk(clk), .reset(reset), .sclk(sclk),
  .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
  .faults(faults), .accel_x(accel_x), .accel_y(accel_y),
  .temp_value(temp_value), .count_value(count_value), .ctrl(ctrl),
  .clear_error(clear_error), .cmd_overrun(cmd_overrun));

/* dv/accel_spi_frame_test.sv */
`timescale 1ns/1ps
module accel_spi_frame_test;
  logic clk;
  logic reset;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  accel_spi_pkg::fault_in_t faults;
  logic [9:0] accel_x;
  logic [9:0] accel_y;
  logic [7:0] temp_value;
  logic [7:0] count_value;
  accel_spi_pkg::ctrl_out_t ctrl;
  logic clear_error;
  logic cmd_overrun;
  logic [15:0] rx;
  logic [15:0] ce_cnt;
  logic [15:0] ovr_cnt;
  int n_mismatch;
  int n_tests;
  int cycles;

  accel_spi_frame i_accel_spi_frame (.clk(clk), .reset(reset),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .faults(faults), .accel_x(accel_x),
    .accel_y(accel_y), .temp_value(temp_value),
    .count_value(count_value), .ctrl(ctrl),
    .clear_error(clear_error), .cmd_overrun(cmd_overrun));
  spi_master_model i_spi_master_model (.sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Status frame with odd parity at bit 12 over the rest
  function automatic logic [15:0] sf(input logic [15:0] w);
    return w | {3'h0, ~^w, 12'h000};
  endfunction : sf

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Mask hides the status bit whose filter sense is not pinned down
  task automatic step(input logic [15:0] cmd, input int n,
                      input logic [15:0] mask, input logic [15:0] exp);
    // Start just after an edge so no pin moves on a clock edge
    @(posedge clk);
    #1 i_spi_master_model.xfer(cmd, n, rx);
    check("answer", rx & mask, exp);
  endtask : step

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (clear_error === 1'b1) begin
      ce_cnt <= ce_cnt + 16'h0001;
    end
    if (cmd_overrun === 1'b1) begin
      ovr_cnt <= ovr_cnt + 16'h0001;
    end
    if (cycles == 10000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    cycles = 0;
    ce_cnt = 16'h0000;
    ovr_cnt = 16'h0000;
    reset = 1'b1;
    faults = '0;
    faults.osc_running = 1'b1;
    faults.init_busy = 1'b1;
    accel_x = 10'h155;
    accel_y = 10'h2AA;
    temp_value = 8'h5A;
    count_value = 8'hC3;
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    repeat (5) @(posedge clk);
    step(16'h2000, 16, 16'hFFFF, sf(16'h0C02));
    step(16'hC000, 16, 16'hFFFF, sf(16'h0C10));
    @(posedge clk);
    #1 faults.init_busy = 1'b0;
    step(16'h6000, 16, 16'hFFF7, 16'hD021);
    step(16'h401B, 16, 16'hFFFF, sf(16'h0C10));
    check("ctrl", {13'h0000, ctrl}, 16'h0007);
    check("clear", ce_cnt, 16'h0001);
    step(16'h80FF, 16, 16'hFFFF, 16'h400B);
    step(16'h8F00, 16, 16'hFFFF, 16'h800B);
    step(16'h9100, 16, 16'hFFFF, 16'h8F5A);
    step(16'hC000, 16, 16'hFFFF, 16'h91C3);
    step(16'h6000, 16, 16'hFFF7, 16'hD000);
    step(16'hE000, 16, 16'hFFFF, sf(16'h2AAA));
    step(16'h4100, 16, 16'hFFFF, sf(16'h0C04));
    step(16'h0000, 16, 16'hFFFF, sf(16'h0C02));
    step(16'h2000, 15, 16'hFFFF, sf(16'h0C02) >> 1);
    step(16'hC000, 16, 16'hFFFF, sf(16'h0C01));
    step(16'hC000, 17, 16'hFFFF, 16'hA000);
    step(16'hC000, 16, 16'hFFFF, sf(16'h0C01));
    @(posedge clk);
    #1 faults.over_temp = 1'b1;
    step(16'h6000, 16, 16'hFFF7, 16'hD000);
    step(16'h2000, 16, 16'hFFFF, sf(16'h0C08));
    @(posedge clk);
    #1 faults.osc_freq_fail = 1'b1;
    step(16'hC000, 16, 16'hFFFF, sf(16'h0C08));
    step(16'h2000, 16, 16'hFFF7, 16'hD050);
    @(posedge clk);
    #1 faults.osc_running = 1'b0;
    step(16'h2000, 16, 16'hFFFF, 16'hFFFF);
    check("overrun", ovr_cnt, 16'h0000);
    report_and_stop();
  end
endmodule : accel_spi_frame_test
